// ===== design/eng_field_defines.svh
`ifndef ENG_FIELD_DEFINES_SVH
`define ENG_FIELD_DEFINES_SVH

// Scan cycle timing
`define SCAN_PERIOD_NS    1477000000
`define CLK_PERIOD_NS     100

// Engineering subfield placement (packet bit numbers)
`define ENG_FIELD_BITS    1792
`define ENG_FIRST         13'd3943
`define ENG_LAST          13'd4111
`define ENG_FILL_START    13'd4108
`define ENG_LOCAL_OFS     13'd2416
`define ENG_VEC_BITS      169

// Analog telemetry board access
`define ADC_SEL_ADDR      20'hc0003
`define ADC_READ_ADDR     20'hc0004
`define ITEM_LAST         4'hf
`define ITEM_MUX_TABLE    {16'h56f3, 16'h139b, 16'h141b, 16'h119b, 16'h131b, 16'h149b, 16'h129b, 16'h121b, \
                           16'h5f75, 16'h5ef5, 16'h5e75, 16'h5df5, 16'h19ab, 16'h345b, 16'h365b, 16'h375b}

// Housekeeping frames
`define HK_CUR_START      13'd144
`define HK_PRV_START      13'd656
`define HK_END            13'd1167
`define HK_WORD_LAST      5'h1f
`define HK_MAJ_LAST       9'd5
`define HK_PAD1_LO        9'd285
`define HK_PAD1_HI        9'd319
`define HK_PAD2_LO        9'd436
`define HK_PAD2_HI        9'd447
`define HK_PAD3           9'd511

// Output buffer
`define OUT_FIFO_DEPTH    16
`define OUT_FIFO_WIDTH    15

`endif

// ===== design/eng_field_pkg.sv
package eng_field_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEL,
        ST_READ,
        ST_ENG,
        ST_HK
    } pack_state_t;

    typedef logic [12:0] pkt_pos_t;
    typedef logic [1:0]  bank_t;
endpackage

// ===== design/engineering_packet_field_packer.sv
// Functional notes
// - Engineering field is fixed layout, 1792 bits
// - Photodiode B temp, 12 bits at 3943
// - Seven 9-bit source temps from 3955
// - Four 12-bit focal plane temps from 4018
// - Bulkhead 4066, scan motor 4075, 9 bits
// - Mirror coupled temps 12 bits at 4084, 4096
// - Four fill bits at 4108
// - Subfield ends 4111; local equals packet minus 2416
// - Refresh and emit every 1.477 s scan
// - Analog reads via C0003/C0004 with mux code
// - Keep current and prior housekeeping frames, rotating
// - Frames at 144 and 656; 6-bit cycle first
// - Bits 0-319 one-second words, pad 285-319
// - Bits 320-447 eight-second words, pad 436-447
// - Bits 448-511 unique words, pad bit 511
`include "eng_field_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module eng_bit_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr, next_wr_ptr;
    logic [AW-1:0]    rd_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count;
    logic             push, pop;
    // Full at DEPTH entries; the filler stalls there rather than dropping bits
    assign in_ready  = (count < (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

module engineering_packet_field_packer import eng_field_pkg::*; #(
    parameter int SCAN_CYCLES = `SCAN_PERIOD_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Analog telemetry board
    output logic             adc_wr,
    output logic             adc_rd,
    output logic [19:0]      adc_addr,
    output logic [15:0]      adc_wdata,
    input  wire logic        adc_rdy,
    input  wire logic [11:0] adc_rdata,
    // Housekeeping words from flight software
    input  wire logic        hk_word_valid,
    input  wire logic [15:0] hk_word,
    input  wire logic [5:0]  major_cycle_number,
    // Packet bit stream
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic             out_packet,
    output logic [12:0]      out_pos,
    output logic             out_bit
);
    localparam int FW = `OUT_FIFO_WIDTH;
    pack_state_t  state, next_state;
    logic [3:0]   item, next_item;
    pkt_pos_t     pos, next_pos;
    logic [11:0]  samp [16];
    logic [11:0]  next_samp [16];
    logic [23:0]  timer, next_timer;
    logic         scan_due, next_scan_due;
    logic         hk_due, next_hk_due;
    logic         next_adc_wr, next_adc_rd;
    logic [19:0]  next_adc_addr;
    logic [15:0]  next_adc_wdata;
    logic [255:0] mux_table;
    logic [`ENG_VEC_BITS-1:0] eng_vec;
    logic [15:0]  hk_mem [3][32];
    logic [5:0]   hk_maj [3];
    logic [4:0]   hk_cnt, next_hk_cnt;
    bank_t        fill_bank, cur_bank, prv_bank;
    bank_t        next_fill_bank, next_cur_bank, next_prv_bank;
    logic         frame_done;
    logic         push_valid, push_ready, push_bit;
    logic         in_prior;
    logic [8:0]   loc;
    bank_t        rd_bank;
    logic [15:0]  rd_word;
    logic         hk_bit;
    logic [FW-1:0] fifo_out;
    assign mux_table = `ITEM_MUX_TABLE;
    // Passive items keep the top 9 of the 12 converter bits
    assign eng_vec = {samp[0],
                      samp[1][11:3], samp[2][11:3], samp[3][11:3], samp[4][11:3],
                      samp[5][11:3], samp[6][11:3], samp[7][11:3],
                      samp[8], samp[9], samp[10], samp[11],
                      samp[12][11:3], samp[13][11:3],
                      samp[14], samp[15],
                      4'h0};
    // Acquisition, scan timing and emission sequencing
    always_comb begin
        next_state     = state;
        next_item      = item;
        next_pos       = pos;
        next_samp      = samp;
        next_adc_wr    = 1'b0;
        next_adc_rd    = 1'b0;
        next_adc_addr  = adc_addr;
        next_adc_wdata = adc_wdata;
        next_scan_due  = scan_due;
        next_hk_due    = hk_due;
        push_valid     = 1'b0;
        push_bit       = 1'b0;
        next_timer     = (timer == '0) ? 24'(SCAN_CYCLES - 1) : timer - 1'b1;
        unique case (state)
            ST_IDLE: begin
                if (scan_due) begin
                    next_scan_due  = 1'b0;
                    next_item      = '0;
                    next_state     = ST_SEL;
                    next_adc_wr    = 1'b1;
                    next_adc_addr  = `ADC_SEL_ADDR;
                    next_adc_wdata = mux_table[255 -: 16];
                end else if (hk_due) begin
                    next_hk_due = 1'b0;
                    next_pos    = `HK_CUR_START;
                    next_state  = ST_HK;
                end
            end
            ST_SEL: begin
                next_adc_rd   = 1'b1;
                next_adc_addr = `ADC_READ_ADDR;
                next_state    = ST_READ;
            end
            ST_READ: begin
                next_adc_rd = !adc_rdy;
                if (adc_rdy) begin
                    next_samp[item] = adc_rdata;
                    if (item == `ITEM_LAST) begin
                        next_pos   = `ENG_FIRST;
                        next_state = ST_ENG;
                    end else begin
                        next_item      = item + 1'b1;
                        next_adc_wr    = 1'b1;
                        next_adc_addr  = `ADC_SEL_ADDR;
                        next_adc_wdata = mux_table[8'(255 - 16 * (int'(item) + 1)) -: 16];
                        next_state     = ST_SEL;
                    end
                end
            end
            ST_ENG: begin
                push_valid = 1'b1;
                push_bit   = eng_vec[8'(`ENG_LAST - pos)];
                if (push_ready) begin
                    next_pos = pos + 1'b1;
                    if (pos == `ENG_LAST) begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_HK: begin
                push_valid = 1'b1;
                push_bit   = hk_bit;
                if (push_ready) begin
                    next_pos = pos + 1'b1;
                    if (pos == `HK_END) begin
                        next_state = ST_IDLE;
                    end
                end
            end
        endcase
        if (timer == '0) begin
            next_scan_due = 1'b1;
        end
        if (frame_done) begin
            next_hk_due = 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= ST_IDLE;
            item      <= '0;
            pos       <= '0;
            timer     <= '0;
            scan_due  <= 1'b0;
            hk_due    <= 1'b0;
            adc_wr    <= 1'b0;
            adc_rd    <= 1'b0;
            adc_addr  <= '0;
            adc_wdata <= '0;
            samp      <= '{default: '0};
        end else begin
            state     <= next_state;
            item      <= next_item;
            pos       <= next_pos;
            timer     <= next_timer;
            scan_due  <= next_scan_due;
            hk_due    <= next_hk_due;
            adc_wr    <= next_adc_wr;
            adc_rd    <= next_adc_rd;
            adc_addr  <= next_adc_addr;
            adc_wdata <= next_adc_wdata;
            samp      <= next_samp;
        end
    end
    // Three banks so a frame being filled never disturbs the two on offer
    assign frame_done = hk_word_valid && (hk_cnt == `HK_WORD_LAST);
    always_comb begin
        next_hk_cnt    = hk_word_valid ? hk_cnt + 1'b1 : hk_cnt;
        next_fill_bank = fill_bank;
        next_cur_bank  = cur_bank;
        next_prv_bank  = prv_bank;
        if (frame_done) begin
            next_cur_bank  = fill_bank;
            next_prv_bank  = cur_bank;
            next_fill_bank = prv_bank;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hk_cnt    <= '0;
            fill_bank <= 2'h0;
            cur_bank  <= 2'h1;
            prv_bank  <= 2'h2;
        end else begin
            hk_cnt    <= next_hk_cnt;
            fill_bank <= next_fill_bank;
            cur_bank  <= next_cur_bank;
            prv_bank  <= next_prv_bank;
        end
    end
    always_ff @(posedge core_clk) begin
        if (hk_word_valid) begin
            hk_mem[fill_bank][hk_cnt] <= hk_word;
            if (hk_cnt == '0) begin
                hk_maj[fill_bank] <= major_cycle_number;
            end
        end
    end
    // Frame bit lookup; a transfer is assumed to finish before the next frame lands
    assign in_prior = (pos >= `HK_PRV_START);
    assign loc      = in_prior ? 9'(pos - `HK_PRV_START) : 9'(pos - `HK_CUR_START);
    assign rd_bank  = in_prior ? prv_bank : cur_bank;
    assign rd_word  = hk_mem[rd_bank][loc[8:4]];
    always_comb begin
        hk_bit = rd_word[4'hf - loc[3:0]];
        if (loc <= `HK_MAJ_LAST) begin
            hk_bit = hk_maj[rd_bank][3'(`HK_MAJ_LAST - loc)];
        end else if (loc >= `HK_PAD1_LO && loc <= `HK_PAD1_HI) begin
            hk_bit = 1'b0;
        end else if (loc >= `HK_PAD2_LO && loc <= `HK_PAD2_HI) begin
            hk_bit = 1'b0;
        end else if (loc == `HK_PAD3) begin
            hk_bit = 1'b0;
        end
    end
    eng_bit_fifo #(.WIDTH (FW), .DEPTH (`OUT_FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),   .reset_n   (reset_n),
        .in_valid  (push_valid), .in_ready  (push_ready),
        .in_data   ({state == ST_HK, pos, push_bit}),
        .out_valid (out_valid),  .out_ready (out_ready),
        .out_data  (fifo_out)
    );
    assign {out_packet, out_pos, out_bit} = fifo_out;

    a_eng_local_range: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_ENG |-> (pos - `ENG_LOCAL_OFS) < 13'(`ENG_FIELD_BITS))
        else $error("engineering bit outside field");
    a_eng_ends_last: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_ENG && push_ready && pos == `ENG_LAST |=> state == ST_IDLE)
        else $error("engineering subfield did not end at its last bit");
    a_eng_first_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_ENG && pos == `ENG_FIRST |-> push_bit == samp[0][11])
        else $error("photodiode B msb not at its start bit");
    a_fill_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_ENG && pos >= `ENG_FILL_START |-> !push_bit)
        else $error("fill bit not zero");
    a_sel_then_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        adc_wr |-> adc_addr == `ADC_SEL_ADDR ##1 adc_rd && adc_addr == `ADC_READ_ADDR)
        else $error("channel select not followed by data read");
    a_scan_refresh: assert property (@(posedge core_clk) disable iff (!reset_n)
        timer == '0 |=> scan_due)
        else $error("scan cycle start lost");
    a_frame_rotate: assert property (@(posedge core_clk) disable iff (!reset_n)
        frame_done |=> prv_bank == $past(cur_bank) && cur_bank == $past(fill_bank))
        else $error("housekeeping frames did not rotate");
    a_hk_pad_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_HK && loc >= `HK_PAD1_LO && loc <= `HK_PAD1_HI |-> !push_bit)
        else $error("one-second padding not zero");
    a_hk_last_pad: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_HK && loc == `HK_PAD3 |-> !push_bit)
        else $error("frame last bit not zero");
    a_hk_ends: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_HK && push_ready && pos == `HK_END |=> state == ST_IDLE)
        else $error("housekeeping transfer overran prior frame");
endmodule

`default_nettype wire

// ===== sim/adc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_board_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Analog telemetry bus
    input  wire logic        adc_wr,
    input  wire logic        adc_rd,
    input  wire logic [19:0] adc_addr,
    input  wire logic [15:0] adc_wdata,
    output logic             adc_rdy,
    output logic [11:0]      adc_rdata,
    // Test control
    input  wire logic        slow,
    output int               bad_cnt
);
    logic [15:0] code;
    int          wait_cnt;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_rdy   <= 1'b0;
            adc_rdata <= 12'h000;
            code      <= 16'h0000;
            wait_cnt  <= 0;
            bad_cnt   <= 0;
        end else begin
            adc_rdy   <= 1'b0;
            // Result is only good with the ready pulse, so it is scrambled otherwise
            adc_rdata <= ~adc_rdata;
            if ((adc_wr && adc_addr !== 20'hc0003) || (adc_rd && adc_addr !== 20'hc0004)) begin
                bad_cnt <= bad_cnt + 1;
            end
            if (adc_wr) begin
                code     <= adc_wdata;
                wait_cnt <= 0;
            end else if (adc_rd && !adc_rdy) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt >= (slow ? 6 : 1)) begin
                    adc_rdy   <= 1'b1;
                    adc_rdata <= code[11:0] ^ 12'h5a5;
                    wait_cnt  <= 0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/engineering_packet_field_packer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module engineering_packet_field_packer_tb;
    localparam int SCAN  = 2000;
    localparam int LIMIT = 20000;
    logic        core_clk;
    logic        reset_n;
    logic        adc_wr;
    logic        adc_rd;
    logic [19:0] adc_addr;
    logic [15:0] adc_wdata;
    logic        adc_rdy;
    logic [11:0] adc_rdata;
    logic        hk_word_valid;
    logic [15:0] hk_word;
    logic [5:0]  major_cycle_number;
    logic        out_valid;
    logic        out_ready;
    logic        out_packet;
    logic [12:0] out_pos;
    logic        out_bit;
    logic        slow;
    int          bad_cnt;
    int          err_count;
    int          n_compared;
    int          cycles;
    int          eng_n;
    int          hk_n;
    logic        got [0:1][0:8191];
    logic [12:0] nxt [0:1];
    logic [12:0] last_eng;
    logic [15:0] code_q [$];
    int          stamp_q [$];
    logic [15:0] mux_code [0:15] = '{16'h56f3, 16'h139b, 16'h141b, 16'h119b, 16'h131b, 16'h149b, 16'h129b,
                                     16'h121b, 16'h5f75, 16'h5ef5, 16'h5e75, 16'h5df5, 16'h19ab, 16'h345b,
                                     16'h365b, 16'h375b};

    engineering_packet_field_packer #(.SCAN_CYCLES(SCAN)) uut (
        .core_clk(core_clk), .reset_n(reset_n), .adc_wr(adc_wr), .adc_rd(adc_rd), .adc_addr(adc_addr),
        .adc_wdata(adc_wdata), .adc_rdy(adc_rdy), .adc_rdata(adc_rdata), .hk_word_valid(hk_word_valid),
        .hk_word(hk_word), .major_cycle_number(major_cycle_number), .out_valid(out_valid),
        .out_ready(out_ready), .out_packet(out_packet), .out_pos(out_pos), .out_bit(out_bit));

    adc_board_model board (
        .core_clk(core_clk), .reset_n(reset_n), .adc_wr(adc_wr), .adc_rd(adc_rd), .adc_addr(adc_addr),
        .adc_wdata(adc_wdata), .adc_rdy(adc_rdy), .adc_rdata(adc_rdata), .slow(slow), .bad_cnt(bad_cnt));

    always #50 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            $display("[ERR] cycle limit expected below %0d seen %0d", LIMIT, cycles);
            give_verdict();
        end
        if (reset_n && adc_wr) begin
            code_q.push_back(adc_wdata);
            if (adc_wdata === 16'h56f3) begin
                stamp_q.push_back(cycles);
            end
        end
        if (reset_n && out_valid === 1'b1 && out_ready) begin
            chk("stream position", nxt[out_packet], {3'b000, out_pos});
            got[out_packet][out_pos] = out_bit;
            if (out_packet) begin
                nxt[1] = (out_pos == 13'd1167) ? 13'd144 : out_pos + 13'd1;
                hk_n++;
            end else begin
                nxt[0] = (out_pos == 13'd4111) ? 13'd3943 : out_pos + 13'd1;
                last_eng = out_pos;
                eng_n++;
            end
        end
    end

    function automatic logic [15:0] hk_w(input logic [15:0] base, input int k);
        return base ^ {k[4:0], k[4:0], k[4:0], 1'b1};
    endfunction

    function automatic logic hk_exp(input logic [15:0] base, input logic [5:0] cyc, input int i);
        logic [15:0] w;
        w = hk_w(base, i / 16);
        if (i < 6) return cyc[5 - i];
        if ((i >= 285 && i <= 319) || (i >= 436 && i <= 447) || i == 511) return 1'b0;
        return w[15 - i % 16];
    endfunction

    task automatic wait_count(input int which, input int target, input int limit);
        int t;
        t = 0;
        while ((which ? hk_n : eng_n) < target && t < limit) begin
            @(negedge core_clk);
            t++;
        end
        chk("stream bits delivered", 16'(target), 16'(which ? hk_n : eng_n));
    endtask

    task automatic test_eng_field();
        int p;
        int w;
        logic [11:0] v;
        logic [11:0] g;
        while (out_valid !== 1'b1) @(negedge core_clk);
        // Drain held off long enough that the 16-deep buffer fills and the packer stalls
        repeat (60) @(posedge core_clk);
        out_ready <= 1'b1;
        wait_count(0, 169, 3000);
        p = 3943;
        for (int i = 0; i < 16; i++) begin
            w = ((i >= 1 && i <= 7) || i == 12 || i == 13) ? 9 : 12;
            v = mux_code[i][11:0] ^ 12'h5a5;
            if (w == 9) v = {3'b000, v[11:3]};
            g = 12'h000;
            for (int b = 0; b < w; b++) g = {g[10:0], got[0][p + b]};
            chk("adc mux code", mux_code[i], code_q[i]);
            chk("engineering item", {4'h0, v}, {4'h0, g});
            p += w;
        end
        chk("fill bits", 16'h0, {12'h0, got[0][4108], got[0][4109], got[0][4110], got[0][4111]});
        chk("local end bit", 16'd1695, 16'(last_eng - 13'd2416));
    endtask

    task automatic test_scan_period();
        @(posedge core_clk);
        slow <= 1'b0;
        wait_count(0, 3 * 169, 3 * SCAN + 500);
        chk("scan spacing", 16'(SCAN), 16'(stamp_q[2] - stamp_q[1]));
        chk("reads per three scans", 16'd48, 16'(code_q.size()));
    endtask

    task automatic send_frame(input logic [15:0] base, input logic [5:0] cyc);
        for (int k = 0; k < 32; k++) begin
            @(posedge core_clk);
            hk_word_valid      <= 1'b1;
            hk_word            <= hk_w(base, k);
            // Cycle number moves after word 0 so a late capture shows up
            major_cycle_number <= (k == 0) ? cyc : ~cyc;
        end
        @(posedge core_clk);
        hk_word_valid <= 1'b0;
    endtask

    task automatic check_frame(input int start, input logic [15:0] base, input logic [5:0] cyc, input string what);
        int bad;
        logic [5:0] c;
        bad = 0;
        for (int i = 0; i < 6; i++) c[5 - i] = got[1][start + i];
        for (int i = 0; i < 512; i++) begin
            if (got[1][start + i] !== hk_exp(base, cyc, i)) bad++;
        end
        chk("frame cycle number", {10'h0, cyc}, {10'h0, c});
        chk(what, 16'h0, 16'(bad));
    endtask

    task automatic test_hk_frames();
        send_frame(16'hc3a5, 6'h21);
        wait_count(1, 1024, 4000);
        check_frame(144, 16'hc3a5, 6'h21, "current frame mismatches");
        send_frame(16'h3c5a, 6'h22);
        wait_count(1, 2048, 4000);
        check_frame(144, 16'h3c5a, 6'h22, "current frame mismatches");
        check_frame(656, 16'hc3a5, 6'h21, "prior frame mismatches");
    endtask

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        out_ready = 1'b0;
        hk_word_valid = 1'b0;
        hk_word = 16'h0000;
        major_cycle_number = 6'h00;
        slow = 1'b1;
        err_count = 0;
        n_compared = 0;
        cycles = 0;
        eng_n = 0;
        hk_n = 0;
        nxt[0] = 13'd3943;
        nxt[1] = 13'd144;
        last_eng = 13'd0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        test_eng_field();
        test_scan_period();
        test_hk_frames();
        chk("board protocol faults", 16'h0, 16'(bad_cnt));
        give_verdict();
    end
endmodule
`default_nettype wire
